// file: hdl/pbs_cap_detect.v
// One-shot feedback capacitor measurement selecting the burst class.
// Assumes comparator inputs already synchronised to clk.
`timescale 1ns/1ns
`include "pbs_regs.vh"
module pbs_cap_detect #(
  parameter MEAS_CYC = `PBS_MEAS_CYC
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // Control
  input  wire       start_ok,
  // Comparators
  input  wire       fb_upper_hit,
  input  wire       fb_lower_hit,
  // Results
  output reg        feedback_discharge_switch,
  output reg        measuring,
  output reg        measured,
  output reg  [1:0] burst_class,
  output reg  [15:0] detect_count
);

  reg        detect_flipflop;
  reg [31:0] win_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      detect_flipflop           <= 1'b0;
      feedback_discharge_switch <= 1'b0;
      measuring                 <= 1'b0;
      measured                  <= 1'b0;
      burst_class               <= `PBS_CLS_NONE;
      detect_count              <= 16'h0000;
      win_q                     <= 32'h00000000;
    end else if (!measured && !measuring) begin
      if (start_ok) begin
        measuring <= 1'b1;                                  // [RL12] [RL13]
      end
    end else if (measuring) begin
      win_q <= win_q + 32'h00000001;
      if (!detect_flipflop && fb_upper_hit) begin
        detect_flipflop           <= 1'b1;                  // [RL14]
        feedback_discharge_switch <= 1'b1;                  // [RL14]
        if (detect_count != 16'hFFFF) begin
          detect_count <= detect_count + 16'h0001;          // [RL14]
        end
      end else if (detect_flipflop && fb_lower_hit) begin
        detect_flipflop           <= 1'b0;                  // [RL15]
        feedback_discharge_switch <= 1'b0;                  // [RL15]
      end
      if (win_q == MEAS_CYC - 1) begin
        measuring                 <= 1'b0;                  // [RL16]
        measured                  <= 1'b1;                  // [RL12]
        detect_flipflop           <= 1'b0;
        feedback_discharge_switch <= 1'b0;
        // Small capacitor charges fast, so a high count means small
        if (detect_count < `PBS_BND_LARGE) begin
          burst_class <= `PBS_CLS_LARGE;                    // [RL9] [RL16]
        end else if (detect_count < `PBS_BND_MID) begin
          burst_class <= `PBS_CLS_MID;
        end else if (detect_count < `PBS_BND_SMALL) begin
          burst_class <= `PBS_CLS_SMALL;
        end else begin
          burst_class <= `PBS_CLS_NONE;                     // [RL11]
        end
      end
    end
  end

endmodule

// file: hdl/pbs_control.v
// Protection blanking, extended blanking and burst entry selection.
// Assumes comparators are asynchronous to mclk; uvlo reset arrives as rst_n.
//
// Summary of operation
// [RL1] Faults and light load must persist 20 ms before any mode entry.
// [RL2] Overload restart path may be extended by the blanking capacitor.
// [RL3] In extendable mode the fault gate stays blocked until extended count completes.
// [RL4] At 20 ms expiry enable extended counter and close charge switch.
// [RL5] Upper comparator at 4.5 V: count up, open charge, close discharge.
// [RL6] Lower comparator at 0.9 V: open discharge, reclose charge.
// [RL7] Repeat until count 256, then stop and assert completion.
// [RL8] Both fault gate inputs high: 30 us spike blank then auto-restart.
// [RL9] Four burst-entry settings chosen by feedback capacitor measurement.
// [RL10] Classes select 1.60/1.42/1.27 V entry and 0.45/0.37/0.31 V limit.
// [RL11] Smallest capacitor class never enters burst, keeps full current limit.
// [RL12] Measure only in first 1 ms after first turn-on, never on restarts.
// [RL13] Postpone measurement while a protection is active before startup.
// [RL14] Feedback at 4.5 V: set detect flip-flop, discharge, count up.
// [RL15] Feedback at 0.5 V: reset detect flip-flop, stop discharging.
// [RL16] After 1 ms window compare count with boundaries, latch thresholds.
// [RL17] Slope-dependent current sense threshold ends the pulse earlier on steep ramps.
// [RL18] Same slope compensation applies to the burst current limit.
// [RL19] Blanking timer starts when feedback exceeds 4.5 V.
// [RL20] Burst only if feedback stays below entry threshold for 20 ms.
// [RL21] Without blanking capacitor the extended count finishes within 0.1 ms. Here extend_enable low bypasses the count entirely.
// [RL22] Comparators synchronised; intervals counted on the internal clock.
`timescale 1ns/1ns
`include "pbs_regs.vh"
module pbs_control #(
  parameter BLANK_CYC = `PBS_BLANK_CYC,
  parameter MEAS_CYC  = `PBS_MEAS_CYC,
  parameter SPIKE_CYC = `PBS_SPIKE_CYC
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // Startup and protection status
  input  wire       first_start,
  input  wire       protect_active,
  input  wire       extend_enable,
  // Feedback comparators
  input  wire       fb_overload_cmp,
  input  wire       fb_below_burst_cmp,
  input  wire       fb_upper_cmp,
  input  wire       fb_lower_cmp,
  // Blanking pin comparators
  input  wire       blank_upper_comparator,
  input  wire       blank_lower_comparator,
  // Current sense slope
  input  wire       cs_slope_steep,
  // Blanking pin switches
  output wire       blank_charge_switch,
  output wire       blank_discharge_switch,
  // Feedback pin measurement
  output wire       feedback_discharge_switch,
  output wire       measuring,
  // Selected thresholds
  output reg  [1:0] burst_entry_threshold,
  output reg  [1:0] burst_current_limit,
  output reg        burst_allowed,
  output reg        slope_comp_active,
  // Mode requests
  output reg        burst_enter,
  output reg        auto_restart,
  output wire       ext_done,
  output wire [15:0] detect_count
);

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire srst_n = rst_sync_q[1];

  localparam NSYNC = 7;
  wire [NSYNC-1:0] raw_in = {cs_slope_steep, blank_lower_comparator, blank_upper_comparator,
                             fb_lower_cmp, fb_upper_cmp, fb_below_burst_cmp, fb_overload_cmp};
  reg  [NSYNC-1:0] meta_q;
  reg  [NSYNC-1:0] sync_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // Only the second stage is read; the first may be metastable
      always @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];                            // [RL22]
          sync_q[gi] <= meta_q[gi];                            // [RL22]
        end
      end
    end
  endgenerate
  wire s_overload = sync_q[0];
  wire s_below    = sync_q[1];
  wire s_fb_up    = sync_q[2];
  wire s_fb_lo    = sync_q[3];
  wire s_bk_up    = sync_q[4];
  wire s_bk_lo    = sync_q[5];
  wire s_steep    = sync_q[6];

  // ----------------------------------------
  // Feedback capacitor measurement
  // ----------------------------------------
  wire       measured;
  wire [1:0] cls;
  wire       start_ok = first_start && !protect_active;        // [RL13]

  pbs_cap_detect #(
    .MEAS_CYC (MEAS_CYC)
  ) u_detect (
    .mclk                      (mclk),
    .rst_n                     (srst_n),
    .start_ok                  (start_ok),
    .fb_upper_hit              (s_fb_up),
    .fb_lower_hit              (s_fb_lo),
    .feedback_discharge_switch (feedback_discharge_switch),
    .measuring                 (measuring),
    .measured                  (measured),
    .burst_class               (cls),
    .detect_count              (detect_count)
  );

  // Threshold codes follow the class code: 0 -> 1.60 V/0.45 V, 1 -> 1.42/0.37, 2 -> 1.27/0.31
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      burst_entry_threshold <= `PBS_CLS_NONE;
      burst_current_limit   <= `PBS_CLS_NONE;
      burst_allowed         <= 1'b0;
      slope_comp_active     <= 1'b0;
    end else begin
      if (measured) begin
        burst_entry_threshold <= cls;                          // [RL10]
        burst_current_limit   <= cls;                          // [RL10]
        burst_allowed         <= (cls != `PBS_CLS_NONE);       // [RL11]
      end
      // Threshold pulled in on steep ramps, in normal and burst limit alike
      slope_comp_active <= s_steep;                            // [RL17] [RL18]
    end
  end

  // ----------------------------------------
  // Built-in blanking timers
  // ----------------------------------------
  reg [31:0] ol_cnt_q;
  reg [31:0] lb_cnt_q;
  reg        ol_expired_q;
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      ol_cnt_q     <= 32'h00000000;
      lb_cnt_q     <= 32'h00000000;
      ol_expired_q <= 1'b0;
      burst_enter  <= 1'b0;
    end else begin
      if (!s_overload) begin
        ol_cnt_q     <= 32'h00000000;
        ol_expired_q <= 1'b0;
      end else if (ol_cnt_q == BLANK_CYC - 1) begin
        ol_expired_q <= 1'b1;                                  // [RL1]
      end else begin
        ol_cnt_q <= ol_cnt_q + 32'h00000001;                   // [RL19]
      end
      // Reset on any rise above threshold guards against load jumps
      if (!s_below || !burst_allowed || burst_enter) begin
        lb_cnt_q <= 32'h00000000;                              // [RL20]
      end else if (lb_cnt_q == BLANK_CYC - 1) begin
        lb_cnt_q <= 32'h00000000;
      end else begin
        lb_cnt_q <= lb_cnt_q + 32'h00000001;
      end
      burst_enter <= burst_allowed && s_below && (lb_cnt_q == BLANK_CYC - 1); // [RL1] [RL20]
    end
  end

  // ----------------------------------------
  // Extended blanking and fault gate
  // ----------------------------------------
  pbs_ext_counter u_ext (
    .mclk                   (mclk),
    .rst_n                  (srst_n),
    .enable                 (ol_expired_q && extend_enable), // [RL2] [RL4]
    .upper_hit              (s_bk_up),
    .lower_hit              (s_bk_lo),
    .blank_charge_switch    (blank_charge_switch),
    .blank_discharge_switch (blank_discharge_switch),
    .done                   (ext_done),
    .count                  ()
  );

  // Basic mode skips the extended count: the gate opens at 20 ms expiry without waiting for ext_done
  wire fault_qualify_gate = ol_expired_q && (ext_done || !extend_enable); // [RL3] [RL21]

  reg [15:0] spike_q;
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      spike_q      <= 16'h0000;
      auto_restart <= 1'b0;
    end else if (!fault_qualify_gate) begin
      spike_q <= 16'h0000;
    end else if (spike_q == SPIKE_CYC - 1) begin
      auto_restart <= 1'b1;                                    // [RL8]
    end else begin
      spike_q <= spike_q + 16'h0001;                           // [RL8]
    end
  end

endmodule

// file: hdl/pbs_ext_counter.v
// Extended blanking counter driving the blanking pin switches.
// Assumes comparator inputs already synchronised to clk.
`timescale 1ns/1ns
`include "pbs_regs.vh"
module pbs_ext_counter #(
  parameter COUNT_W   = 9,
  parameter [8:0] TOTAL = `PBS_EXT_COUNT
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst_n,
  // Control
  input  wire enable,
  // Comparators
  input  wire upper_hit,
  input  wire lower_hit,
  // Switches and result
  output reg  blank_charge_switch,
  output reg  blank_discharge_switch,
  output reg  done,
  output reg  [COUNT_W-1:0] count
);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blank_charge_switch    <= 1'b0;
      blank_discharge_switch <= 1'b0;
      done                   <= 1'b0;
      count                  <= {COUNT_W{1'b0}};
    end else if (!enable) begin
      blank_charge_switch    <= 1'b0;
      blank_discharge_switch <= 1'b0;
      done                   <= 1'b0;
      count                  <= {COUNT_W{1'b0}};
    end else if (!done) begin
      if (!blank_charge_switch && !blank_discharge_switch) begin
        blank_charge_switch <= 1'b1;                        // [RL4]
      end else if (blank_charge_switch && upper_hit) begin
        count                  <= count + 1'b1;             // [RL5]
        blank_charge_switch    <= 1'b0;                     // [RL5]
        blank_discharge_switch <= 1'b1;                     // [RL5]
        if (count + 1'b1 == TOTAL) begin
          done                   <= 1'b1;                   // [RL7]
          blank_discharge_switch <= 1'b0;
        end
      end else if (blank_discharge_switch && lower_hit) begin
        blank_discharge_switch <= 1'b0;                     // [RL6]
        blank_charge_switch    <= 1'b1;                     // [RL6]
      end
    end
  end

endmodule

// file: hdl/pbs_regs.vh
// Constants for the protection blanking and burst select block.
// Assumes a 125 MHz system clock; included by the design files only.
`ifndef PBS_REGS_VH
`define PBS_REGS_VH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define PBS_CLK_MHZ          125
`define PBS_BLANK_MS         20
`define PBS_BLANK_CYC        (`PBS_BLANK_MS * 1000 * `PBS_CLK_MHZ)
`define PBS_SPIKE_US         30
`define PBS_SPIKE_CYC        (`PBS_SPIKE_US * `PBS_CLK_MHZ)
`define PBS_MEAS_MS          1
`define PBS_MEAS_CYC         (`PBS_MEAS_MS * 1000 * `PBS_CLK_MHZ)

// ----------------------------------------
// Extended blanking count
// ----------------------------------------
`define PBS_EXT_COUNT        256

// ----------------------------------------
// Burst class codes (largest capacitor first)
// ----------------------------------------
`define PBS_CLS_LARGE        2'h0
`define PBS_CLS_MID          2'h1
`define PBS_CLS_SMALL        2'h2
`define PBS_CLS_NONE         2'h3

// ----------------------------------------
// Class boundaries on the detection count
// ----------------------------------------
`define PBS_BND_LARGE        16'h0008
`define PBS_BND_MID          16'h0040
`define PBS_BND_SMALL        16'h0180

`endif

// file: verification/pbs_control_properties.sv
// Checker for the blanking and burst select block, bound to its top.
// Assumes one clock and the raw reset port as disable.
`timescale 1ns/1ns
module pbs_control_properties #(
  parameter MEAS_CYC = 125000
) (
  input wire       mclk,
  input wire       rst_n,
  input wire       first_start,
  input wire       protect_active,
  input wire       fb_overload_cmp,
  input wire       fb_upper_cmp,
  input wire       fb_lower_cmp,
  input wire       blank_upper_comparator,
  input wire       blank_lower_comparator,
  input wire       cs_slope_steep,
  input wire       blank_charge_switch,
  input wire       blank_discharge_switch,
  input wire       feedback_discharge_switch,
  input wire       measuring,
  input wire [1:0] burst_entry_threshold,
  input wire       burst_allowed,
  input wire       slope_comp_active,
  input wire       burst_enter,
  input wire       auto_restart,
  input wire       ext_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reg [19:0] mlen_q;
  reg        mdone_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mlen_q  <= 20'h00000;
      mdone_q <= 1'b0;
    end else begin
      mlen_q  <= measuring ? mlen_q + 20'h00001 : 20'h00000;
      mdone_q <= mdone_q | (mlen_q != 20'h00000 && !measuring);
    end
  end
  sequence s_up_hit;  blank_charge_switch && blank_upper_comparator; endsequence
  sequence s_low_hit; blank_discharge_switch && blank_lower_comparator && !ext_done; endsequence
  a_switch_exclusive: assert property (!(blank_charge_switch && blank_discharge_switch))
    else $error("blanking switches closed together");
  a_upper_swaps: assert property (s_up_hit |-> ##[1:5] ((blank_discharge_switch && !blank_charge_switch) || ext_done))
    else $error("upper hit did not swap switches");
  a_lower_swaps: assert property (s_low_hit |-> ##[1:5] (blank_charge_switch || ext_done))
    else $error("lower hit did not reclose charge");
  a_restart_sticky: assert property (auto_restart |=> auto_restart)
    else $error("restart request dropped");
  a_restart_cause: assert property (!fb_overload_cmp [*8] |=> !$rose(auto_restart))
    else $error("restart without overload");
  a_burst_pulse: assert property (burst_enter |=> !burst_enter)
    else $error("burst entry longer than a cycle");
  a_never_class: assert property (burst_entry_threshold == 2'h3 |-> !burst_enter && !burst_allowed)
    else $error("burst in never class");
  a_meas_window: assert property ($fell(measuring) |-> mlen_q >= MEAS_CYC - 2 && mlen_q <= MEAS_CYC + 2)
    else $error("measurement window length");
  a_meas_once: assert property (mdone_q |-> !$rose(measuring))
    else $error("measurement repeated");
  a_meas_blocked: assert property ((protect_active || !first_start) [*5] |-> !$rose(measuring))
    else $error("measurement while blocked");
  a_fb_discharge: assert property (measuring && !feedback_discharge_switch && fb_upper_cmp
    |-> ##[1:5] (feedback_discharge_switch || !measuring))
    else $error("feedback discharge not closed");
  a_fb_release: assert property (measuring && feedback_discharge_switch && fb_lower_cmp
    |-> ##[1:5] (!feedback_discharge_switch || !measuring))
    else $error("feedback discharge not opened");
  a_slope_follow: assert property ($stable(cs_slope_steep) [*8] |-> slope_comp_active == cs_slope_steep)
    else $error("slope flag not following");
endmodule
bind pbs_control pbs_control_properties #(.MEAS_CYC(MEAS_CYC)) u_props (.mclk(mclk), .rst_n(rst_n),
  .first_start(first_start), .protect_active(protect_active), .fb_overload_cmp(fb_overload_cmp),
  .fb_upper_cmp(fb_upper_cmp), .fb_lower_cmp(fb_lower_cmp), .blank_upper_comparator(blank_upper_comparator),
  .blank_lower_comparator(blank_lower_comparator), .cs_slope_steep(cs_slope_steep),
  .blank_charge_switch(blank_charge_switch), .blank_discharge_switch(blank_discharge_switch),
  .feedback_discharge_switch(feedback_discharge_switch), .measuring(measuring),
  .burst_entry_threshold(burst_entry_threshold), .burst_allowed(burst_allowed),
  .slope_comp_active(slope_comp_active), .burst_enter(burst_enter), .auto_restart(auto_restart),
  .ext_done(ext_done));

// file: verification/pbs_far_side.sv
// Pin model: timing capacitors on the blanking and feedback pins.
// Assumes the switch outputs of the block, one clock; speeds set by the bench.
`timescale 1ns/1ns
module pbs_far_side (
  // Clock and ramp lengths in cycles
  input  wire        mclk,
  input  wire [11:0] t_blank,
  input  wire [11:0] t_fb,
  // Switches
  input  wire        blank_charge_switch,
  input  wire        blank_discharge_switch,
  input  wire        feedback_discharge_switch,
  // Comparators
  output wire        blank_upper_comparator,
  output wire        blank_lower_comparator,
  output wire        fb_upper_cmp,
  output wire        fb_lower_cmp
);
  // Pin voltage as a ramp position: 0 is the lower trip, t_x the upper one
  reg [11:0] bpos_q = 12'h000;
  reg [11:0] fpos_q = 12'h000;
  // Discharge wins if both switches close, as a shorted pin would
  always @(posedge mclk) begin
    if (blank_discharge_switch && bpos_q != 12'h000)
      bpos_q <= bpos_q - 12'h001;
    else if (blank_charge_switch && !blank_discharge_switch && bpos_q < t_blank)
      bpos_q <= bpos_q + 12'h001;
    if (feedback_discharge_switch && fpos_q != 12'h000)
      fpos_q <= fpos_q - 12'h001;
    else if (!feedback_discharge_switch && fpos_q < t_fb)
      fpos_q <= fpos_q + 12'h001;
  end
  assign blank_upper_comparator = (bpos_q >= t_blank);
  assign blank_lower_comparator = (bpos_q == 12'h000);
  assign fb_upper_cmp           = (fpos_q >= t_fb);
  assign fb_lower_cmp           = (fpos_q == 12'h000);
endmodule

// file: verification/test_pbs_control.sv
// Testbench for the blanking and burst select block with the pin model.
// Assumes shortened counts; results are matched against queued notes.
`timescale 1ns/1ns
module test_pbs_control;
  localparam BLK = 200;
  localparam MSR = 8000;
  localparam SPK = 10;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         first_start = 1'b0;
  reg         protect_active = 1'b0;
  reg         extend_enable = 1'b0;
  reg         fb_overload_cmp = 1'b0;
  reg         fb_below_burst_cmp = 1'b0;
  reg         cs_slope_steep = 1'b0;
  reg  [11:0] t_blank = 12'h004;
  reg  [11:0] t_fb = 12'h001;
  reg         ar_q = 1'b0, ed_q = 1'b0, mq = 1'b0, bu_q = 1'b0;
  wire        bchg, bdis, fdis, bup, blo, fup, flo, measuring, burst_allowed;
  wire        slope_comp_active, burst_enter, auto_restart, ext_done;
  wire [1:0]  bet, bcl;
  wire [15:0] detect_count;
  integer     num_errors = 0, checked = 0, seed = 57562, r = 0;
  integer     cyc = 0, ovl_cyc = 0, bel_cyc = 0, ups = 0, pend = 0, lo = 0, hi = 0, up_cyc = 0;
  logic [15:0] notes[$];
  pbs_control #(.BLANK_CYC(BLK), .MEAS_CYC(MSR), .SPIKE_CYC(SPK)) uut (.mclk(mclk), .rst_n(rst_n),
    .first_start(first_start), .protect_active(protect_active), .extend_enable(extend_enable),
    .fb_overload_cmp(fb_overload_cmp), .fb_below_burst_cmp(fb_below_burst_cmp), .fb_upper_cmp(fup),
    .fb_lower_cmp(flo), .blank_upper_comparator(bup), .blank_lower_comparator(blo),
    .cs_slope_steep(cs_slope_steep), .blank_charge_switch(bchg), .blank_discharge_switch(bdis),
    .feedback_discharge_switch(fdis), .measuring(measuring), .burst_entry_threshold(bet),
    .burst_current_limit(bcl), .burst_allowed(burst_allowed), .slope_comp_active(slope_comp_active),
    .burst_enter(burst_enter), .auto_restart(auto_restart), .ext_done(ext_done), .detect_count(detect_count));
  pbs_far_side far (.mclk(mclk), .t_blank(t_blank), .t_fb(t_fb), .blank_charge_switch(bchg),
    .blank_discharge_switch(bdis), .feedback_discharge_switch(fdis), .blank_upper_comparator(bup),
    .blank_lower_comparator(blo), .fb_upper_cmp(fup), .fb_lower_cmp(flo));
  initial forever #4 mclk = ~mclk;
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // An unexpected result finds an empty queue and never matches
  task automatic take(input string what, input logic [15:0] seen);
    logic [15:0] exp;
    exp = (notes.size() != 0) ? notes.pop_front() : 16'hFFFF;
    check(what, seen, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    up_cyc <= rst_n ? up_cyc + 1 : 0;
    ovl_cyc <= fb_overload_cmp ? ovl_cyc + 1 : 0;
    bel_cyc <= fb_below_burst_cmp ? bel_cyc + 1 : 0;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  // Result watcher: takes the oldest note for each result that appears
  always @(negedge mclk) begin
    pend = (mq && !measuring) ? 4 : (pend != 0 ? pend - 1 : 0);
    if (bup && !bu_q) ups = ups + 1;
    if (rst_n && auto_restart && !ar_q) take("restart", {4'h1, 11'h000, ovl_cyc >= lo && ovl_cyc <= hi});
    if (rst_n && burst_enter) take("burst", {4'h2, 11'h000, bel_cyc >= lo && bel_cyc <= hi});
    if (rst_n && ext_done && !ed_q) take("extend", {4'h3, 3'h0, ups[8:0]});
    if (pend == 1) take("class", {4'h4, 5'h00, burst_allowed, 2'h0, bcl, bet});
    ar_q = auto_restart;
    ed_q = ext_done;
    mq = measuring;
    bu_q = bup;
  end
  initial forever begin
    repeat (8) @(posedge mclk);
    // Synchroniser plus register settle well inside the eight cycles a value stands
    #1;
    if (rst_n && up_cyc > 8) check("slope", {15'h0000, slope_comp_active}, {15'h0000, cs_slope_steep});
    r = $random(seed);
    cs_slope_steep = r[0];
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic tick(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic end_test(input string name);
    check("pending notes", 16'(notes.size()), 16'h0000);
    notes.delete();
    $display("test %s done, %0d checks so far", name, checked);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    {first_start, protect_active, extend_enable, fb_overload_cmp, fb_below_burst_cmp} = 5'h00;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    check("reset outputs", {10'h000, bet, bcl, auto_restart, ext_done}, 16'h003C);
  endtask
  // Pin ramp length sets the cycle count and so the class
  task automatic measure(input logic [1:0] cls, input logic [11:0] tfb, input logic prot);
    integer n;
    do_reset;
    t_fb = tfb;
    notes.push_back({4'h4, 5'h00, cls != 2'h3, 2'h0, cls, cls});
    protect_active = prot;
    first_start = 1'b1;
    tick(100);
    check("held measurement", {15'h0000, measuring}, 16'h0000 | prot ^ 1'b1);
    protect_active = 1'b0;
    tick(MSR + 40);
    // One ramp up and one down per count, each with three cycles of response
    n = MSR / (2 * tfb + 6);
    check("detect count", {15'h0000, detect_count + 4 >= n && detect_count <= n + 4}, 16'h0001);
    first_start = 1'b0;
    tick(8);
    first_start = 1'b1;
    tick(40);
    check("repeat measurement", {15'h0000, measuring}, 16'h0000);
    end_test("measure");
  endtask
  // A short rise above the entry level must restart the count
  task automatic burst(input logic expect_it);
    lo = BLK;
    hi = BLK + 8;
    if (expect_it) notes.push_back({4'h2, 12'h001});
    fb_below_burst_cmp = 1'b1;
    tick(BLK / 2);
    fb_below_burst_cmp = 1'b0;
    tick(4);
    fb_below_burst_cmp = 1'b1;
    tick(BLK + 12);
    fb_below_burst_cmp = 1'b0;
    end_test("burst");
  endtask
  // A short overload first; then a held one with the timed window
  task automatic overload(input logic ext, input integer plo, input integer phi);
    do_reset;
    extend_enable = ext;
    fb_overload_cmp = 1'b1;
    tick(BLK - 20);
    fb_overload_cmp = 1'b0;
    tick(4);
    ups = 0;
    lo = plo;
    hi = phi;
    if (ext) notes.push_back({4'h3, 3'h0, 9'h100});
    notes.push_back({4'h1, 12'h001});
    fb_overload_cmp = 1'b1;
    tick(phi + 10);
    end_test("overload");
  endtask
  initial begin
    measure(2'h0, 12'h3E8, 1'b0);
    burst(1'b1);
    measure(2'h1, 12'h096, 1'b1);
    measure(2'h2, 12'h014, 1'b0);
    measure(2'h3, 12'h001, 1'b0);
    burst(1'b0);
    overload(1'b1, BLK + SPK + 510 * 4, BLK + SPK + 512 * 10 + 20);
    overload(1'b0, BLK + SPK, BLK + SPK + 12);
    tally_and_finish;
  end
endmodule
